// >>> rtl/hwmla_defs.svh
`ifndef HWMLA_DEFS_SVH
`define HWMLA_DEFS_SVH
// Function
// - once started, sweep all channels and store each result
// - compare each result with its limits, record in readable status
// - sweep four voltages, own supply, two remote temps, local temp
// - sample cpu voltage code pins into a readable register
// - a change of the cpu voltage code raises an alert event
// - strap enable low at power-up: address from strap select
// - strap enable high at power-up: fixed address 0x2e
// - first written byte loads the address pointer
// - alert pin driven low while any status bit is set
// - per-event mask bit keeps that event off the alert
// - alert can be placed on either of two shared pins
// - temperature readings get a signed per-channel offset
// - per-fan start temperature sets where fan control begins
// - per-output ramp register sets temperature-to-speed slope
// - dynamic mode steps start temperature so zone temperature settles at operating point
// - all control goes through register accesses only
// - slave address latched on first match, later strap changes ignored
// - second written byte stored in the register at the pointer
`define HW_BUS_PTR   1'b0
`define HW_BUS_DATA  1'b1
`define HW_R_VAL     8'h20
`define HW_R_CFG     8'h40
`define HW_R_STAT    8'h41
`define HW_R_STAT2   8'h42
`define HW_R_VCODE   8'h43
`define HW_R_LIM_LO  8'h50
`define HW_R_LIM_HI  8'h58
`define HW_R_SLOPE   8'h60
`define HW_R_OPPT    8'h63
`define HW_R_FST     8'h67
`define HW_R_OFS     8'h70
`define HW_R_MASK    8'h74
`define HW_R_MASK2   8'h75
`define HW_CFG_START 0
`define HW_CFG_AL_EN 1
`define HW_CFG_AL_B  2
`define HW_CFG_AUTO  3
`define HW_CFG_DYN   4
`define HW_ADDR_DEF  7'h2e
`define HW_ADDR_SEL  7'h2c
`define HW_FIRST_T   3'h5
`define HW_LAST_CH   3'h7
`define HW_LIM_LO_RST 8'h00
`define HW_LIM_HI_RST 8'hff
`define HW_FST_RST   8'h40
`define HW_SLOPE_RST 8'h04
`define HW_OPPT_RST  8'h50
`endif

// >>> rtl/hwmla_pkg.sv
package hwmla_pkg;
    // gray along idle -> start -> wait -> store
    typedef enum logic [1:0] {
        HWMLA_IDLE  = 2'h0,
        HWMLA_START = 2'h1,
        HWMLA_WAIT  = 2'h3,
        HWMLA_STORE = 2'h2
    } hwmla_state_t;
    typedef logic [7:0] hwmla_byte_t;
endpackage : hwmla_pkg

// >>> rtl/hwmla_core.sv
`timescale 1ns/1ns
`include "hwmla_defs.svh"
module hwmla_core
    import hwmla_pkg::*;
#(
    parameter int NCH    = 8,
    parameter int NTEMP  = 3,
    parameter int NFAN   = 2,
    parameter int VCW    = 6
) (
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic              ce,
    input  wire logic              bus_addr,
    input  wire logic [7:0]        bus_wdata,
    input  wire logic              bus_wr,
    input  wire logic              bus_rd,
    output logic [7:0]             bus_rdata,
    input  wire logic [6:0]        smb_addr,
    input  wire logic              smb_addr_valid,
    output logic                   smb_addr_match,
    output logic [2:0]             adc_chan,
    output logic                   adc_start,
    input  wire logic              adc_done,
    input  wire logic [7:0]        adc_data,
    input  wire logic [VCW-1:0]    cpu_voltage_code,
    input  wire logic              strap_en_pin,
    input  wire logic              strap_sel_pin,
    input  wire logic              prim_a_o,
    input  wire logic              prim_a_oe_n,
    input  wire logic              prim_b_o,
    input  wire logic              prim_b_oe_n,
    output logic                   pin_a_o,
    output logic                   pin_a_oe_n,
    output logic                   pin_b_o,
    output logic                   pin_b_oe_n,
    output logic [NFAN-1:0][7:0]   fan_duty,
    output logic                   irq
);

    // saturating fan duty from temperature above start
    function automatic hwmla_byte_t duty_calc(
        input hwmla_byte_t t,
        input hwmla_byte_t st,
        input hwmla_byte_t sl
    );
        logic [15:0] p;
        p = 16'({8'h00, t} - {8'h00, st}) * 16'(sl);
        if (t <= st) begin
            duty_calc = 8'h00;
        end else if (p > 16'h00ff) begin
            duty_calc = 8'hff;
        end else begin
            duty_calc = p[7:0];
        end
    endfunction : duty_calc

    // pin synchronisers, first stage read only by second
    logic [VCW-1:0] vc_s1;
    logic [VCW-1:0] vc_s2;
    logic [1:0]     st_s1;
    logic [1:0]     st_s2;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            vc_s1 <= '0;
            vc_s2 <= '0;
            st_s1 <= 2'h0;
            st_s2 <= 2'h0;
        end else if (ce) begin
            vc_s1 <= cpu_voltage_code;
            vc_s2 <= vc_s1;
            st_s1 <= {strap_en_pin, strap_sel_pin};
            st_s2 <= st_s1;
        end
    end

    // register state
    hwmla_state_t      state;
    logic [2:0]        ch;
    hwmla_byte_t       ptr;
    hwmla_byte_t       cfg;
    logic [NCH:0]      stat;
    logic [NCH:0]      mask;
    logic [VCW-1:0]    vcode;
    logic [1:0]        boot;
    logic [1:0]        straps;
    logic              addr_lock;
    logic [6:0]        addr_q;
    hwmla_byte_t       val   [NCH];
    hwmla_byte_t       lim_lo[NCH];
    hwmla_byte_t       lim_hi[NCH];
    hwmla_byte_t       ofs   [NTEMP];
    hwmla_byte_t       fst   [NFAN];
    hwmla_byte_t       slope [NFAN];
    hwmla_byte_t       oppt  [NFAN];

    hwmla_state_t      next_state;
    logic [2:0]        next_ch;
    hwmla_byte_t       next_ptr;
    hwmla_byte_t       next_cfg;
    logic [NCH:0]      next_stat;
    logic [NCH:0]      next_mask;
    logic [VCW-1:0]    next_vcode;
    logic [1:0]        next_boot;
    logic [1:0]        next_straps;
    logic              next_addr_lock;
    logic [6:0]        next_addr_q;
    hwmla_byte_t       next_val   [NCH];
    hwmla_byte_t       next_lim_lo[NCH];
    hwmla_byte_t       next_lim_hi[NCH];
    hwmla_byte_t       next_ofs   [NTEMP];
    hwmla_byte_t       next_fst   [NFAN];
    hwmla_byte_t       next_slope [NFAN];
    hwmla_byte_t       next_oppt  [NFAN];
    hwmla_byte_t       next_rdata;
    logic [NFAN-1:0][7:0] next_duty;
    logic [6:0]        sel_addr;

    // strap-selected address until the first match pins it
    always_comb begin
        if (straps[1]) begin
            sel_addr = `HW_ADDR_DEF;
        end else begin
            sel_addr = `HW_ADDR_SEL | {6'h00, straps[0]};
        end
        if (addr_lock) begin
            smb_addr_match = smb_addr_valid && smb_addr == addr_q;
        end else begin
            smb_addr_match = smb_addr_valid && smb_addr == sel_addr && boot == 2'h3; // no match before capture
        end
    end

    // level alert; mask bit keeps its event off the pin
    assign irq        = |(stat & ~mask);
    assign adc_start  = state == HWMLA_START;
    assign adc_chan   = ch;

    // alert on pin a or b, primary function otherwise
    always_comb begin
        pin_a_o    = prim_a_o;
        pin_a_oe_n = prim_a_oe_n;
        pin_b_o    = prim_b_o;
        pin_b_oe_n = prim_b_oe_n;
        if (cfg[`HW_CFG_AL_EN] && !cfg[`HW_CFG_AL_B]) begin
            pin_a_o    = 1'b0;
            pin_a_oe_n = !irq;
        end
        if (cfg[`HW_CFG_AL_EN] && cfg[`HW_CFG_AL_B]) begin
            pin_b_o    = 1'b0;
            pin_b_oe_n = !irq;
        end
    end

    // next values of all register state
    always_comb begin
        hwmla_byte_t  adj;
        logic [2:0]   ti;
        logic [NCH:0] set;
        logic [NCH:0] clr;
        logic [7:0]   wa;
        adj            = adc_data;
        ti             = ch - `HW_FIRST_T;
        set            = '0;
        clr            = '0;
        wa             = ptr;
        next_state     = state;
        next_ch        = ch;
        next_ptr       = ptr;
        next_cfg       = cfg;
        next_mask      = mask;
        next_vcode     = vcode;
        next_boot      = boot;
        next_straps    = straps;
        next_addr_lock = addr_lock;
        next_addr_q    = addr_q;
        next_val       = val;
        next_lim_lo    = lim_lo;
        next_lim_hi    = lim_hi;
        next_ofs       = ofs;
        next_fst       = fst;
        next_slope     = slope;
        next_oppt      = oppt;
        next_rdata     = 8'h00;

        // straps taken once the synchronisers have filled
        if (boot != 2'h3) begin
            next_boot = boot + 2'h1;
            if (boot == 2'h2) begin
                next_straps = st_s2;
            end
        end
        if (!addr_lock && smb_addr_match) begin
            next_addr_lock = 1'b1;
            next_addr_q    = sel_addr;
        end

        // code change flags an event after the first load
        if (boot == 2'h2) begin
            next_vcode = vc_s2;
        end else if (boot == 2'h3 && vc_s2 != vcode) begin
            next_vcode = vc_s2;
            set[NCH]   = 1'b1;
        end

        // measurement sweep
        if (ch >= `HW_FIRST_T) begin
            adj = adc_data + ofs[ti[1:0]];
        end
        case (state)
            HWMLA_IDLE: begin
                if (cfg[`HW_CFG_START]) begin
                    next_state = HWMLA_START;
                end
            end
            HWMLA_START: begin
                next_state = HWMLA_WAIT;
            end
            HWMLA_WAIT: begin
                if (adc_done) begin
                    next_val[ch] = adj;
                    next_state   = HWMLA_STORE;
                end
            end
            HWMLA_STORE: begin
                // limits checked on the stored value
                if (val[ch] < lim_lo[ch] || val[ch] > lim_hi[ch]) begin
                    set[ch] = 1'b1;
                end
                next_ch = ch + 3'h1;
                if (ch == `HW_LAST_CH && cfg[`HW_CFG_DYN]) begin
                    for (int f = 0; f < NFAN; f++) begin
                        if (val[5 + f] > oppt[f] && fst[f] != 8'h00) begin
                            next_fst[f] = fst[f] - 8'h01;
                        end else if (val[5 + f] < oppt[f] && fst[f] != 8'hff) begin
                            next_fst[f] = fst[f] + 8'h01;
                        end
                    end
                end
                if (cfg[`HW_CFG_START]) begin
                    next_state = HWMLA_START;
                end else begin
                    next_state = HWMLA_IDLE;
                end
            end
            default: begin
                next_state = HWMLA_IDLE;
            end
        endcase

        // pointer port and data port
        if (bus_wr && bus_addr == `HW_BUS_PTR) begin
            next_ptr = bus_wdata;
        end
        if (bus_wr && bus_addr == `HW_BUS_DATA) begin
            if (wa == `HW_R_CFG) begin
                next_cfg = bus_wdata;
            end else if (wa == `HW_R_STAT) begin
                clr[NCH-1:0] = bus_wdata;
            end else if (wa == `HW_R_STAT2) begin
                clr[NCH] = bus_wdata[0];
            end else if (wa == `HW_R_MASK) begin
                next_mask[NCH-1:0] = bus_wdata;
            end else if (wa == `HW_R_MASK2) begin
                next_mask[NCH] = bus_wdata[0];
            end
            for (int i = 0; i < NCH; i++) begin
                if (wa == `HW_R_LIM_LO + 8'(i)) begin
                    next_lim_lo[i] = bus_wdata;
                end
                if (wa == `HW_R_LIM_HI + 8'(i)) begin
                    next_lim_hi[i] = bus_wdata;
                end
            end
            for (int i = 0; i < NTEMP; i++) begin
                if (wa == `HW_R_OFS + 8'(i)) begin
                    next_ofs[i] = bus_wdata;
                end
            end
            for (int i = 0; i < NFAN; i++) begin
                if (wa == `HW_R_FST + 8'(i)) begin
                    next_fst[i] = bus_wdata;
                end
                if (wa == `HW_R_SLOPE + 8'(i)) begin
                    next_slope[i] = bus_wdata;
                end
                if (wa == `HW_R_OPPT + 8'(i)) begin
                    next_oppt[i] = bus_wdata;
                end
            end
        end
        // an event in the clearing cycle survives
        next_stat = (stat & ~clr) | set;

        // read mux, answered the cycle after the strobe
        if (bus_rd && bus_addr == `HW_BUS_PTR) begin
            next_rdata = ptr;
        end else if (bus_rd) begin
            if (wa == `HW_R_CFG) begin
                next_rdata = cfg;
            end else if (wa == `HW_R_STAT) begin
                next_rdata = stat[NCH-1:0];
            end else if (wa == `HW_R_STAT2) begin
                next_rdata = {7'h00, stat[NCH]};
            end else if (wa == `HW_R_MASK) begin
                next_rdata = mask[NCH-1:0];
            end else if (wa == `HW_R_MASK2) begin
                next_rdata = {7'h00, mask[NCH]};
            end else if (wa == `HW_R_VCODE) begin
                next_rdata = 8'(vcode);
            end
            for (int i = 0; i < NCH; i++) begin
                if (wa == `HW_R_VAL + 8'(i)) begin
                    next_rdata = val[i];
                end
                if (wa == `HW_R_LIM_LO + 8'(i)) begin
                    next_rdata = lim_lo[i];
                end
                if (wa == `HW_R_LIM_HI + 8'(i)) begin
                    next_rdata = lim_hi[i];
                end
            end
            for (int i = 0; i < NTEMP; i++) begin
                if (wa == `HW_R_OFS + 8'(i)) begin
                    next_rdata = ofs[i];
                end
            end
            for (int i = 0; i < NFAN; i++) begin
                if (wa == `HW_R_FST + 8'(i)) begin
                    next_rdata = fst[i];
                end
                if (wa == `HW_R_SLOPE + 8'(i)) begin
                    next_rdata = slope[i];
                end
                if (wa == `HW_R_OPPT + 8'(i)) begin
                    next_rdata = oppt[i];
                end
            end
        end

        // fan duty from zone temperature; fans off in manual
        for (int f = 0; f < NFAN; f++) begin
            if (cfg[`HW_CFG_AUTO]) begin
                next_duty[f] = duty_calc(val[5 + f], fst[f], slope[f]);
            end else begin
                next_duty[f] = 8'h00;
            end
        end
    end

    // registers only; ce freezes everything
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state     <= HWMLA_IDLE;
            ch        <= 3'h0;
            ptr       <= 8'h00;
            cfg       <= 8'h00;
            stat      <= '0;
            mask      <= '0;
            vcode     <= '0;
            boot      <= 2'h0;
            straps    <= 2'h3;
            addr_lock <= 1'b0;
            addr_q    <= `HW_ADDR_DEF;
            bus_rdata <= 8'h00;
            fan_duty  <= '0;
            for (int i = 0; i < NCH; i++) begin
                val[i]    <= 8'h00;
                lim_lo[i] <= `HW_LIM_LO_RST;
                lim_hi[i] <= `HW_LIM_HI_RST;
            end
            for (int i = 0; i < NTEMP; i++) begin
                ofs[i] <= 8'h00;
            end
            for (int i = 0; i < NFAN; i++) begin
                fst[i]   <= `HW_FST_RST;
                slope[i] <= `HW_SLOPE_RST;
                oppt[i]  <= `HW_OPPT_RST;
            end
        end else if (ce) begin
            state     <= next_state;
            ch        <= next_ch;
            ptr       <= next_ptr;
            cfg       <= next_cfg;
            stat      <= next_stat;
            mask      <= next_mask;
            vcode     <= next_vcode;
            boot      <= next_boot;
            straps    <= next_straps;
            addr_lock <= next_addr_lock;
            addr_q    <= next_addr_q;
            bus_rdata <= next_rdata;
            fan_duty  <= next_duty;
            val       <= next_val;
            lim_lo    <= next_lim_lo;
            lim_hi    <= next_lim_hi;
            ofs       <= next_ofs;
            fst       <= next_fst;
            slope     <= next_slope;
            oppt      <= next_oppt;
        end
    end

endmodule : hwmla_core

// >>> tb/hwmla_core_sva.sv
`timescale 1ns/1ns
`include "hwmla_defs.svh"
module hwmla_core_sva (
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic       bus_rd,
    input wire logic [7:0] bus_rdata,
    input wire logic [6:0] smb_addr,
    input wire logic       smb_addr_valid,
    input wire logic       smb_addr_match,
    input wire logic [2:0] adc_chan,
    input wire logic       adc_start,
    input wire logic       adc_done,
    input wire logic       strap_en_pin,
    input wire logic       strap_sel_pin,
    input wire logic       prim_a_oe_n,
    input wire logic       prim_b_oe_n,
    input wire logic       pin_a_o,
    input wire logic       pin_a_oe_n,
    input wire logic       pin_b_o,
    input wire logic       pin_b_oe_n,
    input wire logic       irq
);
    logic [2:0] boot_cnt, next_boot_cnt, exp_chan, next_exp_chan;
    logic       cap_en, next_cap_en, cap_sel, next_cap_sel;
    logic [6:0] exp_addr;

    // strap copy taken late, once the pins have passed the synchronisers
    always_comb begin
        next_boot_cnt = (boot_cnt == 3'h7) ? boot_cnt : boot_cnt + 3'h1;
        next_cap_en   = (boot_cnt == 3'h5) ? strap_en_pin : cap_en;
        next_cap_sel  = (boot_cnt == 3'h5) ? strap_sel_pin : cap_sel;
        next_exp_chan = adc_start ? adc_chan + 3'h1 : exp_chan;
        if (!rst_n) begin
            next_boot_cnt = 3'h0;
            next_exp_chan = 3'h0;
        end
    end
    always_ff @(posedge core_clk) begin
        boot_cnt <= next_boot_cnt;
        cap_en   <= next_cap_en;
        cap_sel  <= next_cap_sel;
        exp_chan <= next_exp_chan;
    end
    assign exp_addr = cap_en ? `HW_ADDR_DEF : (`HW_ADDR_SEL | {6'h00, cap_sel});

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    chk_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
        else $error("read data outside its slot");
    chk_start_pulse: assert property (adc_start |=> !adc_start)
        else $error("conversion start longer than one cycle");
    chk_chan_order: assert property (adc_start |-> adc_chan == exp_chan)
        else $error("channel out of sequence");
    chk_done_next: assert property (adc_done |-> ##[2:3] adc_start)
        else $error("sweep stalled after a result");
    chk_early_match: assert property (boot_cnt < 3'h3 |-> !smb_addr_match)
        else $error("address match before straps captured");
    chk_addr_match: assert property (boot_cnt == 3'h7 && smb_addr_valid |->
        smb_addr_match == (smb_addr == exp_addr)) else $error("slave address match wrong");
    chk_pin_a_alert: assert property (!pin_a_oe_n && prim_a_oe_n |-> irq && !pin_a_o)
        else $error("pin a driven without alert");
    chk_pin_b_alert: assert property (!pin_b_oe_n && prim_b_oe_n |-> irq && !pin_b_o)
        else $error("pin b driven without alert");
endmodule : hwmla_core_sva

bind hwmla_core hwmla_core_sva u_sva (.core_clk, .rst_n, .bus_rd, .bus_rdata, .smb_addr, .smb_addr_valid,
    .smb_addr_match, .adc_chan, .adc_start, .adc_done, .strap_en_pin, .strap_sel_pin, .prim_a_oe_n,
    .prim_b_oe_n, .pin_a_o, .pin_a_oe_n, .pin_b_o, .pin_b_oe_n, .irq);

// >>> tb/hwmla_adc_model.sv
`timescale 1ns/1ns
module hwmla_adc_model (
    input wire logic            core_clk,
    input wire logic            rst_n,
    input wire logic [2:0]      adc_chan,
    input wire logic            adc_start,
    input wire logic            slow,
    input wire logic [7:0][7:0] tab,
    output logic                adc_done,
    output logic [7:0]          adc_data
);
    int cnt;

    // one answer per start; data toggles between answers, never holds the last
    always @(posedge core_clk) begin
        adc_done <= 1'b0;
        adc_data <= ~adc_data;
        if (!rst_n) begin
            cnt <= 0;
        end else if (adc_start) begin
            cnt <= slow ? 6 : 1;
        end else if (cnt == 1) begin
            adc_done <= 1'b1;
            adc_data <= tab[adc_chan];
            cnt      <= 0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
    initial adc_data = 8'h00;
endmodule : hwmla_adc_model

// >>> tb/test_hwmla_core.sv
`timescale 1ns/1ns
`include "hwmla_defs.svh"
module test_hwmla_core
    import hwmla_pkg::*;
;
    logic core_clk, rst_n, ce, bus_addr, bus_wr, bus_rd, smb_addr_valid, smb_addr_match, adc_start, adc_done;
    logic strap_en_pin, strap_sel_pin, prim_a_o, prim_a_oe_n, prim_b_o, prim_b_oe_n, slow, irq;
    logic pin_a_o, pin_a_oe_n, pin_b_o, pin_b_oe_n;
    logic [7:0]      bus_wdata, bus_rdata, adc_data, got, st;
    logic [6:0]      smb_addr;
    logic [2:0]      adc_chan;
    logic [5:0]      cpu_voltage_code;
    logic [1:0][7:0] fan_duty;
    logic [7:0][7:0] tab, ofs;
    logic [31:0]     seed = 32'h00012164;
    int              n_mismatch, n_compared;

    hwmla_core uut (.core_clk, .rst_n, .ce, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .smb_addr,
        .smb_addr_valid, .smb_addr_match, .adc_chan, .adc_start, .adc_done, .adc_data, .cpu_voltage_code,
        .strap_en_pin, .strap_sel_pin, .prim_a_o, .prim_a_oe_n, .prim_b_o, .prim_b_oe_n, .pin_a_o,
        .pin_a_oe_n, .pin_b_o, .pin_b_oe_n, .fan_duty, .irq);
    hwmla_adc_model adc (.core_clk, .rst_n, .adc_chan, .adc_start, .slow, .tab, .adc_done, .adc_data);

    // free-running 125 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    function automatic logic [7:0] exp_val(int ch);
        return tab[ch] + ofs[ch]; // wraps like the stored reading
    endfunction : exp_val
    function automatic logic [7:0] exp_duty(logic [7:0] t);
        logic [9:0] p;
        p = {2'h0, t - 8'h40} << 2;
        return (t <= 8'h40) ? 8'h00 : (p > 10'h0ff) ? 8'hff : p[7:0];
    endfunction : exp_duty

    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", s, e, g);
            n_mismatch++;
        end
    endtask : chk
    task automatic wr(input logic a, input logic [7:0] d);
        @(posedge core_clk);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_wr    <= 1'b1;
        @(posedge core_clk);
        bus_wr <= 1'b0;
    endtask : wr
    task automatic wreg(input logic [7:0] r, input logic [7:0] d);
        wr(`HW_BUS_PTR, r);
        wr(`HW_BUS_DATA, d);
        @(posedge core_clk); // written state landed at the edge before; registered outputs follow at this one
    endtask : wreg
    // pointer then read; data is only valid in the slot after the strobe
    task automatic rchk(input string s, input logic [7:0] r, input logic [7:0] e);
        wr(`HW_BUS_PTR, r);
        @(posedge core_clk);
        bus_addr <= `HW_BUS_DATA;
        bus_rd   <= 1'b1;
        @(posedge core_clk);
        bus_rd <= 1'b0;
        #1 chk(s, e, bus_rdata);
    endtask : rchk
    task automatic boot(input logic en, input logic sel);
        strap_en_pin  <= en;
        strap_sel_pin <= sel;
        rst_n         <= 1'b0;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
    endtask : boot
    task automatic addr(input logic [6:0] a, input logic e);
        @(posedge core_clk);
        smb_addr       <= a;
        smb_addr_valid <= 1'b1;
        #1 chk("match", {7'h00, e}, {7'h00, smb_addr_match});
        @(posedge core_clk);
        smb_addr_valid <= 1'b0;
    endtask : addr
    // several sweeps, each with the converter fast or slow at random
    task automatic sweeps(input int n);
        repeat (n) begin
            slow <= ^xs();
            repeat (100) @(posedge core_clk);
        end
    endtask : sweeps
    task automatic stop_test();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test

    // a full run needs about 1050 cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        stop_test();
    end

    initial begin
        {rst_n, bus_addr, bus_wr, bus_rd, smb_addr_valid, slow, bus_wdata, smb_addr} = '0;
        ce = 1'b1;
        cpu_voltage_code = 6'h15;
        {prim_a_o, prim_b_o, prim_a_oe_n, prim_b_oe_n} = 4'h3;
        tab = '0;
        ofs = '0;
        boot(1'b1, 1'b0);
        addr(`HW_ADDR_DEF, 1'b0);
        repeat (12) @(posedge core_clk);
        rchk("cfg", `HW_R_CFG, 8'h00);
        rchk("lim_hi", `HW_R_LIM_HI, `HW_LIM_HI_RST);
        rchk("lim_lo", `HW_R_LIM_LO + 8'h03, `HW_LIM_LO_RST);
        rchk("fan_start", `HW_R_FST, `HW_FST_RST);
        rchk("slope", `HW_R_SLOPE, `HW_SLOPE_RST);
        rchk("op_point", `HW_R_OPPT, `HW_OPPT_RST);
        rchk("unmapped", 8'h30, 8'h00);
        $display("done: defaults");
        for (int ch = 0; ch < 8; ch++) begin
            tab[ch] = xs();
            ofs[ch] = (ch >= 5) ? (xs() & 8'h07) : 8'h00;
        end
        tab[5] = 8'h48 | (xs() & 8'h1f);
        tab[1] = tab[1] | 8'h01;
        st = 8'h00;
        for (int ch = 0; ch < 8; ch++) begin
            if (ch >= 5) wreg(`HW_R_OFS + ch - 5, ofs[ch]);
            if (ch[0] && exp_val(ch) != 8'h00) begin
                wreg(`HW_R_LIM_HI + ch, exp_val(ch) - 8'h01);
                st[ch] = 1'b1;
            end
        end
        rchk("lim_hi", `HW_R_LIM_HI + 8'h01, exp_val(1) - 8'h01);
        wreg(`HW_R_MASK, 8'hff);
        wreg(`HW_R_MASK2, 8'hff);
        wreg(`HW_R_CFG, 8'h09);
        sweeps(3);
        wreg(`HW_R_VAL, 8'h5a);
        for (int ch = 0; ch < 8; ch++) rchk("value", `HW_R_VAL + ch, exp_val(ch));
        rchk("status", `HW_R_STAT, st);
        chk("duty", exp_duty(exp_val(5)), fan_duty[0]);
        chk("duty1", exp_duty(exp_val(6)), fan_duty[1]);
        chk("irq masked", 8'h00, {7'h00, irq});
        wreg(`HW_R_MASK, 8'h00);
        chk("irq", 8'h01, {7'h00, irq});
        $display("done: sweep");
        prim_b_o    <= xs() & 1;
        prim_b_oe_n <= 1'b0;
        wreg(`HW_R_CFG, 8'h03);
        chk("pin a", 8'h00, {6'h00, pin_a_o, pin_a_oe_n});
        chk("pin b", {6'h00, prim_b_o, 1'b0}, {6'h00, pin_b_o, pin_b_oe_n});
        prim_b_oe_n <= 1'b1;
        wreg(`HW_R_CFG, 8'h07);
        chk("pin b", 8'h00, {6'h00, pin_b_o, pin_b_oe_n});
        chk("pin a", {6'h00, prim_a_o, prim_a_oe_n}, {6'h00, pin_a_o, pin_a_oe_n});
        for (int ch = 0; ch < 8; ch++) wreg(`HW_R_LIM_HI + ch, 8'hff);
        sweeps(2);
        wreg(`HW_R_STAT, 8'hff);
        rchk("status clear", `HW_R_STAT, 8'h00);
        chk("pin b idle", 8'h01, {7'h00, pin_b_oe_n});
        $display("done: alert");
        wreg(`HW_R_MASK2, 8'h00);
        cpu_voltage_code <= 6'h2a;
        repeat (10) @(posedge core_clk);
        rchk("code", `HW_R_VCODE, 8'h2a);
        rchk("status2", `HW_R_STAT2, 8'h01);
        chk("irq code", 8'h01, {7'h00, irq});
        wreg(`HW_R_STAT2, 8'h01);
        chk("irq clear", 8'h00, {7'h00, irq});
        $display("done: code");
        wreg(`HW_R_FST, 8'h01);
        wreg(`HW_R_OPPT, 8'h00);
        wreg(`HW_R_CFG, 8'h11);
        sweeps(2);
        rchk("fan start dyn", `HW_R_FST, 8'h00);
        $display("done: dynamic");
        boot(1'b0, 1'b1);
        repeat (12) @(posedge core_clk);
        addr(`HW_ADDR_DEF, 1'b0);
        addr(7'h2d, 1'b1);
        strap_sel_pin <= 1'b0;
        repeat (6) @(posedge core_clk);
        addr(7'h2d, 1'b1);
        addr(`HW_ADDR_SEL, 1'b0);
        boot(1'b0, 1'b0);
        repeat (12) @(posedge core_clk);
        addr(`HW_ADDR_SEL, 1'b1);
        boot(1'b1, 1'b1);
        repeat (12) @(posedge core_clk);
        addr(7'h2d, 1'b0);
        addr(`HW_ADDR_DEF, 1'b1);
        $display("done: address");
        stop_test();
    end
endmodule : test_hwmla_core
